// ### hw/srl_pkg.sv
// Constants for the latch set/reset source selection block
// Functional notes
// RULE1 - With the pin-set enable on, a high latch input pin sets the latch; off, the pin is ignored.
// RULE2 - With the clock-set enable on, each divider pulse sets the latch; off, pulses are ignored.
// RULE3 - With the comparator-set enable on, a high comparator output sets the latch.
// RULE4 - With the pin-reset enable on, a high latch input pin resets the latch.
// RULE5 - The comparator output is low when non-inverting is below inverting, high when above.
// RULE6 - Reserved bits 5 and 1 of the source enables have no function and read as zero.
// RULE7 - Clock-reset enable pulses reset from the divider; comparator-reset resets on high.
// RULE8 - The divider makes a one-cycle pulse every 2^(n+2) cycles, n the 3-bit select.
// RULE9 - Writing 1 to soft pulse set or reset drives that input for one cycle; both read 0.
package srl_pkg;
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] MAIN_CTRL_OFF = 4'h0;
  localparam logic [3:0] SRC_EN_OFF = 4'h1;
  localparam logic [3:0] STATUS_OFF = 4'h2;
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] SRC_EN_RST = 8'h00;
  // Main control fields
  localparam int LATCH_EN_BIT = 7;
  localparam int DIV_SEL_LSB = 4;
  localparam int DIV_SEL_W = 3;
  localparam int Q_OE_BIT = 3;
  localparam int NQ_OE_BIT = 2;
  localparam int PULSE_SET_BIT = 1;
  localparam int PULSE_RST_BIT = 0;
  // Stored main bits; the pulse bits are never stored
  localparam logic [7:0] MAIN_STORE_MASK = 8'hfc;
  // Source enable fields
  localparam int PIN_SET_BIT = 7;
  localparam int CLK_SET_BIT = 6;
  localparam int RSVD_HI_BIT = 5;
  localparam int CMP_SET_BIT = 4;
  localparam int PIN_RST_BIT = 3;
  localparam int CLK_RST_BIT = 2;
  localparam int RSVD_LO_BIT = 1;
  localparam int CMP_RST_BIT = 0;
  localparam logic [7:0] SRC_EN_MASK = 8'hdd;
  // Status fields
  localparam int ST_Q_BIT = 0;
  localparam int ST_SET_BIT = 1;
  localparam int ST_RST_BIT = 2;
  localparam int ST_CMP_BIT = 3;
  localparam int ST_DIV_BIT = 4;
  // Divider: exponent offset and counter width for code 111
  localparam int DIV_BASE_EXP = 2;
  localparam int DIV_CNT_W = 9;
  // Soft pulse width in core clock periods
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_PULSE_NS = 100;
  localparam int SOFT_PULSE_CYC = (SOFT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### hw/srl_clk_divider.sv
// Periodic pulse generator for the latch clock source
`timescale 1ns/10ps
`default_nettype none
module srl_clk_divider
  import srl_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [DIV_SEL_W-1:0] div_sel, // Rate code
  output logic latch_divider_pulse // One-cycle pulse
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] mask;
  logic next_pulse;

  // Pulse when the low n+2 bits are all ones [RULE8]
  always_comb begin
    mask = CNT_W'((1 << (int'(div_sel) + DIV_BASE_EXP)) - 1);
    next_cnt = cnt + 1'b1;
    next_pulse = ((cnt & mask) == mask);
  end

  // Free-running count, so a rate change takes effect at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      latch_divider_pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      latch_divider_pulse <= next_pulse;
    end
  end

  // Any pulse leaves the low two count bits at zero, so a gap of three quiet cycles
  // holds at every code; the fourth cycle must pulse if code 0 was selected
  a_div_fast_rate: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
    latch_divider_pulse |=> (!latch_divider_pulse)[*3]
      ##1 (latch_divider_pulse || $past(div_sel) != 3'h0))
    else $error("divider pulse spacing wrong at code 0");
endmodule
`default_nettype wire

// ### hw/srl_cmp_slicer.sv
// Digital output stage of the analog comparator
`timescale 1ns/10ps
`default_nettype none
module srl_cmp_slicer #(
  parameter int VW = 10
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [VW-1:0] noninverting_voltage, // Plus input level
  input wire logic [VW-1:0] inverting_voltage, // Minus input level
  output logic cmp_level // Digital result
);
  logic next_level;

  // Equal inputs hold the last result, standing in for hysteresis
  always_comb begin
    next_level = cmp_level;
    if (noninverting_voltage > inverting_voltage) begin
      next_level = 1'b1; // [RULE5]
    end else if (noninverting_voltage < inverting_voltage) begin
      next_level = 1'b0; // [RULE5]
    end
  end

  // Result latched each clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_level <= 1'b0;
    end else begin
      cmp_level <= next_level;
    end
  end

  a_cmp_goes_high: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    (noninverting_voltage > inverting_voltage) |=> cmp_level)
    else $error("comparator not high when plus above minus");
  a_cmp_goes_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    (noninverting_voltage < inverting_voltage) |=> !cmp_level)
    else $error("comparator not low when plus below minus");
endmodule
`default_nettype wire

// ### hw/srl_source_select.sv
// Set/reset source selection and latch for the SR latch peripheral
`timescale 1ns/10ps
`default_nettype none
module srl_source_select
  import srl_pkg::*;
#(
  parameter int VW = 10
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [7:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [7:0] rd_data, // Read data, cycle after strobe
  input wire logic latch_input_pin, // External latch input
  input wire logic [VW-1:0] noninverting_voltage, // Comparator plus
  input wire logic [VW-1:0] inverting_voltage, // Comparator minus
  output logic latch_set, // Set input of latch
  output logic latch_reset, // Reset input of latch
  output logic latch_q, // Latch state
  output logic latch_q_out, // Q for pin, gated by enable
  output logic latch_nq_out, // Inverted Q for pin, gated
  output logic cmp_out // Comparator digital output
);
  // Register address match, shared by write and read paths
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    reg_hit = (a == off);
  endfunction

  // Software-visible state
  logic [7:0] main_ctrl;
  logic [7:0] src_en;
  logic pulse_set;
  logic pulse_rst;
  logic [7:0] next_main_ctrl;
  logic [7:0] next_src_en;
  logic next_pulse_set;
  logic next_pulse_rst;

  // Latch-side state
  logic next_set;
  logic next_reset;
  logic next_q;
  logic next_q_out;
  logic next_nq_out;
  logic next_cmp_out;
  logic [7:0] next_rd_data;

  // Sub-block outputs
  logic div_pulse;
  logic cmp_level;
  logic latch_en;
  logic set_cause;
  logic rst_cause;

  assign latch_en = main_ctrl[LATCH_EN_BIT];

  // Rate generator for the clock sources
  srl_clk_divider #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div_sel(main_ctrl[DIV_SEL_LSB +: DIV_SEL_W]),
    .latch_divider_pulse(div_pulse)
  );

  // Comparator output stage
  srl_cmp_slicer #(
    .VW(VW)
  ) u_cmp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .noninverting_voltage(noninverting_voltage),
    .inverting_voltage(inverting_voltage),
    .cmp_level(cmp_level)
  );

  // Register writes; pulse bits become single-cycle strobes
  always_comb begin
    next_main_ctrl = main_ctrl;
    next_src_en = src_en;
    next_pulse_set = 1'b0;
    next_pulse_rst = 1'b0;
    if (wr_en && reg_hit(addr, MAIN_CTRL_OFF)) begin
      next_main_ctrl = wr_data & MAIN_STORE_MASK;
      next_pulse_set = wr_data[PULSE_SET_BIT]; // [RULE9]
      next_pulse_rst = wr_data[PULSE_RST_BIT]; // [RULE9]
    end
    if (wr_en && reg_hit(addr, SRC_EN_OFF)) begin
      next_src_en = wr_data & SRC_EN_MASK; // Reserved bits never stored [RULE6]
    end
  end

  // Register file flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_ctrl <= MAIN_CTRL_RST;
      src_en <= SRC_EN_RST;
      pulse_set <= 1'b0;
      pulse_rst <= 1'b0;
    end else begin
      main_ctrl <= next_main_ctrl;
      src_en <= next_src_en;
      pulse_set <= next_pulse_set;
      pulse_rst <= next_pulse_rst;
    end
  end

  // Source gating: each pin, divider and comparator source passes only with its enable; soft pulses pass ungated
  always_comb begin
    set_cause = pulse_set; // [RULE9]
    set_cause = set_cause | (latch_input_pin & src_en[PIN_SET_BIT]); // [RULE1]
    set_cause = set_cause | (div_pulse & src_en[CLK_SET_BIT]); // [RULE2]
    set_cause = set_cause | (cmp_level & src_en[CMP_SET_BIT]); // [RULE3]
    rst_cause = pulse_rst; // [RULE9]
    rst_cause = rst_cause | (latch_input_pin & src_en[PIN_RST_BIT]); // [RULE4]
    rst_cause = rst_cause | (div_pulse & src_en[CLK_RST_BIT]); // [RULE7]
    rst_cause = rst_cause | (cmp_level & src_en[CMP_RST_BIT]); // [RULE7]
  end

  // Latch next state; reset dominates so a stuck set cannot hold it
  always_comb begin
    next_set = set_cause;
    next_reset = rst_cause;
    next_q = latch_q;
    if (!latch_en) begin
      next_q = 1'b0; // Disabled latch rests cleared
    end else if (rst_cause) begin
      next_q = 1'b0;
    end else if (set_cause) begin
      next_q = 1'b1;
    end
    next_q_out = latch_en & main_ctrl[Q_OE_BIT] & next_q;
    next_nq_out = latch_en & main_ctrl[NQ_OE_BIT] & ~next_q;
    next_cmp_out = cmp_level;
  end

  // Latch and pin flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_set <= 1'b0;
      latch_reset <= 1'b0;
      latch_q <= 1'b0;
      latch_q_out <= 1'b0;
      latch_nq_out <= 1'b0;
      cmp_out <= 1'b0;
    end else begin
      latch_set <= next_set;
      latch_reset <= next_reset;
      latch_q <= next_q;
      latch_q_out <= next_q_out;
      latch_nq_out <= next_nq_out;
      cmp_out <= next_cmp_out;
    end
  end

  // Read mux; data valid only in the cycle after the strobe
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en) begin
      if (reg_hit(addr, MAIN_CTRL_OFF)) begin
        next_rd_data = main_ctrl; // Pulse bits read zero [RULE9]
      end else if (reg_hit(addr, SRC_EN_OFF)) begin
        next_rd_data = src_en & SRC_EN_MASK; // [RULE6]
      end else if (reg_hit(addr, STATUS_OFF)) begin
        next_rd_data[ST_Q_BIT] = latch_q;
        next_rd_data[ST_SET_BIT] = latch_set;
        next_rd_data[ST_RST_BIT] = latch_reset;
        next_rd_data[ST_CMP_BIT] = cmp_level;
        next_rd_data[ST_DIV_BIT] = div_pulse;
      end
    end
  end

  // Read data flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // Steps of the software pulse sequence and of the enable register read
  sequence s_pulse_set_write;
    wr_en && reg_hit(addr, MAIN_CTRL_OFF) && wr_data[PULSE_SET_BIT];
  endsequence
  sequence s_pulse_rst_write;
    wr_en && reg_hit(addr, MAIN_CTRL_OFF) && wr_data[PULSE_RST_BIT];
  endsequence
  sequence s_main_read;
    rd_en && reg_hit(addr, MAIN_CTRL_OFF);
  endsequence
  sequence s_src_read;
    rd_en && reg_hit(addr, SRC_EN_OFF);
  endsequence

  // Each enabled source must reach its latch input one edge later
  a_pin_set_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    (latch_input_pin && src_en[PIN_SET_BIT]) |=> latch_set)
    else $error("pin did not set latch");
  a_clk_set_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
    (div_pulse && src_en[CLK_SET_BIT]) |=> latch_set)
    else $error("divider pulse did not set latch");
  a_cmp_set_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
    (cmp_level && src_en[CMP_SET_BIT]) |=> latch_set)
    else $error("comparator did not set latch");
  a_set_has_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    latch_set |-> $past(pulse_set
      || (latch_input_pin && src_en[PIN_SET_BIT])
      || (div_pulse && src_en[CLK_SET_BIT])
      || (cmp_level && src_en[CMP_SET_BIT])))
    else $error("set asserted with no enabled source");
  a_pin_rst_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    (latch_input_pin && src_en[PIN_RST_BIT]) |=> latch_reset)
    else $error("pin did not reset latch");
  a_clk_rst_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
    (div_pulse && src_en[CLK_RST_BIT]) |=> latch_reset)
    else $error("divider pulse did not reset latch");
  a_rst_has_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
    latch_reset |-> $past(pulse_rst
      || (latch_input_pin && src_en[PIN_RST_BIT])
      || (div_pulse && src_en[CLK_RST_BIT])
      || (cmp_level && src_en[CMP_RST_BIT])))
    else $error("reset asserted with no enabled source");
  a_rsvd_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    s_src_read |=> (rd_data[RSVD_HI_BIT] == 1'b0 && rd_data[RSVD_LO_BIT] == 1'b0))
    else $error("reserved enable bit read as one");
  a_soft_set_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
    s_pulse_set_write |=> pulse_set ##1 latch_set)
    else $error("soft set pulse missing");
  a_soft_rst_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
    s_pulse_rst_write |=> pulse_rst ##1 latch_reset)
    else $error("soft reset pulse missing");
  a_pulse_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
    s_main_read |=> rd_data[1:0] == 2'b00)
    else $error("pulse bits did not read as zero");

  // Comparator reset path
  a_cmp_rst_path: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
    (cmp_level && src_en[CMP_RST_BIT]) |=> latch_reset)
    else $error("comparator did not reset latch");

  // Latch steps: the causes seen at one edge decide Q at the next
  sequence s_set_only;
    latch_en && set_cause && !rst_cause;
  endsequence
  sequence s_rst_any;
    latch_en && rst_cause;
  endsequence
  sequence s_no_cause;
    latch_en && !set_cause && !rst_cause;
  endsequence
  sequence s_latch_off;
    !latch_en;
  endsequence

  a_set_takes_q: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    s_set_only |=> latch_q)
    else $error("latch did not set on a lone set cause");
  // Reset must win a tie, otherwise a stuck set source would pin Q high
  a_reset_wins_q: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    s_rst_any |=> !latch_q)
    else $error("latch did not reset");
  a_q_holds_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    s_no_cause |=> $stable(latch_q))
    else $error("latch moved with no cause");
  a_q_cleared_off: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    s_latch_off |=> !latch_q)
    else $error("disabled latch not cleared");

  // Pin outputs copy the latch state only while enabled and never show both phases
  a_q_out_match: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
    latch_q_out |-> latch_q)
    else $error("Q output high while latch clear");
  a_nq_out_match: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    latch_nq_out |-> !latch_q)
    else $error("inverted output high while latch set");

  // The comparator output pin lags the level by one clock
  a_cmp_out_delay: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    1'b1 |=> (cmp_out == $past(cmp_level)))
    else $error("comparator output pin out of step");

  // A soft pulse lasts one cycle unless software writes the register again
  a_set_pulse_once: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
    pulse_set |=> (!pulse_set || $past(wr_en && reg_hit(addr, MAIN_CTRL_OFF))))
    else $error("soft set pulse longer than one cycle");
  a_rst_pulse_once: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
    pulse_rst |=> (!pulse_rst || $past(wr_en && reg_hit(addr, MAIN_CTRL_OFF))))
    else $error("soft reset pulse longer than one cycle");

  // Read data stands one cycle only, so a stale word cannot be taken twice
  sequence s_status_read;
    rd_en && reg_hit(addr, STATUS_OFF);
  endsequence
  a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    !rd_en |=> (rd_data == 8'h00))
    else $error("read data not zero outside a read");
  a_status_bits: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
    s_status_read |=> (rd_data[ST_Q_BIT] == $past(latch_q)
      && rd_data[ST_CMP_BIT] == $past(cmp_level)))
    else $error("status bits do not match latch state");
endmodule
`default_nettype wire

// ### testbench/srl_far_side.sv
// Behavioural far side: the latch input pin and the comparator input levels
`timescale 1ns/10ps
`default_nettype none
module srl_far_side #(
  parameter int VW = 10
) (
  input wire logic core_clk, // System clock
  input wire logic pin_req, // Pin level asked by the bench
  input wire logic [VW-1:0] plus_req, // Plus level asked by the bench
  input wire logic [VW-1:0] minus_req, // Minus level asked by the bench
  output var logic latch_input_pin = 1'b0, // Pin level seen by the block
  output var logic [VW-1:0] noninverting_voltage = '0, // Plus level seen
  output var logic [VW-1:0] inverting_voltage = '0 // Minus level seen
);
  // Levels move one edge late, so the block never sees a change on its own edge
  always @(posedge core_clk) begin
    latch_input_pin <= pin_req;
    noninverting_voltage <= plus_req;
    inverting_voltage <= minus_req;
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the latch source selection block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  import srl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pin_req = 1'b0;
  logic [9:0] plus_req = 10'h000;
  logic [9:0] minus_req = 10'h000;
  logic [7:0] rd_data;
  logic latch_set, latch_reset, latch_q, latch_q_out, latch_nq_out, cmp_out;
  wire logic latch_input_pin;
  wire logic [9:0] noninverting_voltage;
  wire logic [9:0] inverting_voltage;
  int err_count = 0;
  int checks_done = 0;

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  srl_far_side #(.VW(10)) far (
    .core_clk(core_clk), .pin_req(pin_req), .plus_req(plus_req),
    .minus_req(minus_req), .latch_input_pin(latch_input_pin),
    .noninverting_voltage(noninverting_voltage), .inverting_voltage(inverting_voltage)
  );

  srl_source_select #(.VW(10)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .latch_input_pin(latch_input_pin), .noninverting_voltage(noninverting_voltage),
    .inverting_voltage(inverting_voltage), .latch_set(latch_set),
    .latch_reset(latch_reset), .latch_q(latch_q), .latch_q_out(latch_q_out),
    .latch_nq_out(latch_nq_out), .cmp_out(cmp_out)
  );

  // Sample just after an edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp,
    input logic [7:0] msk = 8'hff);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data & msk, exp)
  endtask

  task automatic drive(input logic p, input logic [9:0] vp, input logic [9:0] vn);
    @(posedge core_clk);
    pin_req <= p;
    plus_req <= vp;
    minus_req <= vn;
    tick(4);
  endtask

  // Count cycles with set or reset high; the window length fixes the expectation
  task automatic count_hi(input int n, output int ns, output int nr);
    ns = 0;
    nr = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      ns += int'(latch_set === 1'b1);
      nr += int'(latch_reset === 1'b1);
    end
  endtask

  task automatic end_sim;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs far fewer cycles than this
  initial begin
    #2_000_000;
    err_count++;
    end_sim();
  end

  initial begin
    int ns, nr;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_rd(MAIN_CTRL_OFF, MAIN_CTRL_RST);
    reg_rd(SRC_EN_OFF, SRC_EN_RST);
    reg_wr(SRC_EN_OFF, 8'hff);
    reg_rd(SRC_EN_OFF, 8'hdd);
    reg_wr(4'hf, 8'hff);
    reg_rd(4'hf, 8'h00);
    $display("test registers done");
    // Pin source, first with both pin enables off
    reg_wr(SRC_EN_OFF, 8'h00);
    reg_wr(MAIN_CTRL_OFF, 8'h8c);
    drive(1'b1, 10'h000, 10'h000);
    `CHK(latch_set, 1'b0)
    `CHK(latch_reset, 1'b0)
    reg_wr(SRC_EN_OFF, 8'h80);
    tick(3);
    `CHK(latch_set, 1'b1)
    `CHK(latch_q, 1'b1)
    `CHK(latch_q_out, 1'b1)
    `CHK(latch_nq_out, 1'b0)
    reg_wr(SRC_EN_OFF, 8'h08);
    tick(3);
    `CHK(latch_set, 1'b0)
    `CHK(latch_reset, 1'b1)
    `CHK(latch_q, 1'b0)
    `CHK(latch_q_out, 1'b0)
    `CHK(latch_nq_out, 1'b1)
    drive(1'b0, 10'h000, 10'h000);
    `CHK(latch_reset, 1'b0)
    // A disabled latch stops driving the inverted pin output
    reg_wr(MAIN_CTRL_OFF, 8'h0c);
    tick(2);
    `CHK(latch_nq_out, 1'b0)
    reg_wr(MAIN_CTRL_OFF, 8'h8c);
    $display("test pin source done");
    // Comparator at the smallest winning margin
    reg_wr(SRC_EN_OFF, 8'h10);
    drive(1'b0, 10'h101, 10'h100);
    `CHK(cmp_out, 1'b1)
    `CHK(latch_set, 1'b1)
    `CHK(latch_q, 1'b1)
    reg_rd(STATUS_OFF, 8'h0b, 8'h0f);
    reg_wr(SRC_EN_OFF, 8'h01);
    tick(3);
    `CHK(latch_set, 1'b0)
    `CHK(latch_reset, 1'b1)
    drive(1'b0, 10'h0ff, 10'h100);
    `CHK(cmp_out, 1'b0)
    `CHK(latch_reset, 1'b0)
    $display("test comparator source done");
    // Every divider code: two periods from any phase hold exactly two pulses
    reg_wr(SRC_EN_OFF, 8'h44);
    for (int s = 0; s < 8; s++) begin
      reg_wr(MAIN_CTRL_OFF, {1'b1, 3'(s), 4'h0});
      tick(2);
      count_hi(2 << (s + DIV_BASE_EXP), ns, nr);
      `CHK(ns, 2)
      `CHK(nr, 2)
    end
    reg_wr(SRC_EN_OFF, 8'h00);
    tick(2);
    count_hi(64, ns, nr);
    `CHK(ns, 0)
    `CHK(nr, 0)
    $display("test divider source done");
    // Soft pulses are one cycle wide and never read back
    reg_wr(MAIN_CTRL_OFF, 8'h82);
    count_hi(8, ns, nr);
    `CHK(ns, SOFT_PULSE_CYC)
    reg_wr(MAIN_CTRL_OFF, 8'h81);
    count_hi(8, ns, nr);
    `CHK(nr, SOFT_PULSE_CYC)
    reg_rd(MAIN_CTRL_OFF, 8'h80);
    $display("test soft pulse done");
    // Reset in mid-run clears the enables again
    reg_wr(SRC_EN_OFF, 8'hdd);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_rd(SRC_EN_OFF, SRC_EN_RST);
    reg_rd(MAIN_CTRL_OFF, MAIN_CTRL_RST);
    `CHK(latch_set, 1'b0)
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
